// ==== design/pasd_top.sv ====
`timescale 1ns/1ps
// How it works
// - source select 000 ignores every source; shutdown never starts
// - code 001 trips when comparator one is high
// - code 010 trips when comparator two is high
// - code 011 trips when either comparator is high
// - code 100 trips when the fault input is low
// - code 101 trips on fault low or comparator one high
// - code 110 trips on fault low or comparator two high
// - code 111 trips on fault low or either comparator high
// - with auto restart on, flag clears itself once the trip is gone
module pasd_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire pasd_pkg::pasd_addr_t paddr,
    input wire pasd_pkg::pasd_data_t pwdata,
    output pasd_pkg::pasd_data_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fault_input,
    input wire logic comparator_one,
    input wire logic comparator_two,
    input wire logic pwm_in_a,
    input wire logic pwm_in_b,
    input wire logic pwm_in_c,
    input wire logic pwm_in_d,
    output logic pwm_out_a,
    output logic pwm_out_b,
    output logic pwm_out_c,
    output logic pwm_out_d,
    output logic pwm_oe_a,
    output logic pwm_oe_b,
    output logic pwm_oe_c,
    output logic pwm_oe_d,
    output logic shutdown_event_flag
);
    import pasd_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic src_trip(input pasd_src_t sel,
                                      input logic flt_low,
                                      input logic c1,
                                      input logic c2);
        logic t;
        t = 1'b0;
        unique case (sel)
            SRC_OFF: t = 1'b0;
            SRC_C1: t = c1;
            SRC_C2: t = c2;
            SRC_C1_C2: t = c1 | c2;
            SRC_FLT: t = flt_low;
            SRC_FLT_C1: t = flt_low | c1;
            SRC_FLT_C2: t = flt_low | c2;
            SRC_ALL: t = flt_low | c1 | c2;
        endcase
        return t;
    endfunction

    // returns {oe, level} for one pin
    function automatic logic [1:0] pin_drive(input logic shut,
                                             input pasd_pair_t st,
                                             input logic pwm);
        logic [1:0] r;
        r = {1'b1, pwm};
        if (shut) begin
            if (st[PAIR_TRI_BIT]) begin
                r = 2'b00;
            end else if (st == PAIR_HIGH) begin
                r = 2'b11;
            end else begin
                r = 2'b10;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int N_IN = 3;
    localparam logic [N_IN-1:0] IN_IDLE = {CMP_IDLE, CMP_IDLE, FAULT_IDLE};
    logic [N_IN-1:0] raw_in;
    logic [N_IN-1:0] sync_in;
    assign raw_in = {comparator_two, comparator_one, fault_input};

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_sync
            pasd_sync #(.RST_VAL(IN_IDLE[gi])) u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .async_in(raw_in[gi]),
                .level_out(sync_in[gi])
            );
        end
    endgenerate

    logic fault_s;
    logic cmp1_s;
    logic cmp2_s;
    assign fault_s = sync_in[ST_FAULT_BIT];
    assign cmp1_s = sync_in[ST_CMP1_BIT];
    assign cmp2_s = sync_in[ST_CMP2_BIT];

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic pready_ff;
    logic pslverr_ff;
    pasd_data_t prdata_ff;
    logic access;
    logic wr_done;
    logic hit;
    pasd_data_t rd_word;
    logic flag_ff;
    pasd_src_t src_ff;
    pasd_pair_t ac_ff;
    pasd_pair_t bd_ff;
    logic restart_ff;
    logic trip;

    assign access = psel & penable;
    assign wr_done = access & pready_ff & pwrite;

    always_comb begin
        rd_word = '0;
        hit = 1'b1;
        unique case (paddr)
            ADDR_CTRL: begin
                rd_word[FLAG_BIT] = flag_ff;
                rd_word[SRC_HI:SRC_LO] = src_ff;
                rd_word[AC_HI:AC_LO] = ac_ff;
                rd_word[BD_HI:BD_LO] = bd_ff;
            end
            ADDR_RESTART: begin
                rd_word[RESTART_BIT] = restart_ff;
            end
            ADDR_STATUS: begin
                rd_word[ST_FAULT_BIT] = fault_s;
                rd_word[ST_CMP1_BIT] = cmp1_s;
                rd_word[ST_CMP2_BIT] = cmp2_s;
                rd_word[ST_TRIP_BIT] = trip;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // one wait state: pready rises on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= access & ~pready_ff;
            pslverr_ff <= access & ~pready_ff &
                          (~hit | (pwrite & (paddr == ADDR_STATUS)));
            if (access & ~pready_ff & ~pwrite) begin
                prdata_ff <= rd_word;
            end else begin
                prdata_ff <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_restart;
    assign wr_ctrl = wr_done & (paddr == ADDR_CTRL);
    assign wr_restart = wr_done & (paddr == ADDR_RESTART);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ff <= CTRL_RST[SRC_HI:SRC_LO];
            ac_ff <= CTRL_RST[AC_HI:AC_LO];
            bd_ff <= CTRL_RST[BD_HI:BD_LO];
        end else if (wr_ctrl) begin
            src_ff <= pwdata[SRC_HI:SRC_LO];
            ac_ff <= pwdata[AC_HI:AC_LO];
            bd_ff <= pwdata[BD_HI:BD_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_ff <= RESTART_RST[RESTART_BIT];
        end else if (wr_restart) begin
            restart_ff <= pwdata[RESTART_BIT];
        end
    end

    // ------------------------------------------------------------
    // shutdown event flag
    // ------------------------------------------------------------
    logic sw_clr;
    logic auto_clr;
    logic nxt_flag;
    assign trip = src_trip(src_ff, ~fault_s, cmp1_s, cmp2_s);
    assign sw_clr = wr_ctrl & ~pwdata[FLAG_BIT];
    assign auto_clr = restart_ff & ~trip;
    // a trip in the clearing cycle wins
    assign nxt_flag = trip | (flag_ff & ~sw_clr & ~auto_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= CTRL_RST[FLAG_BIT];
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // ------------------------------------------------------------
    // output override
    // ------------------------------------------------------------
    logic [1:0] drv_a;
    logic [1:0] drv_b;
    logic [1:0] drv_c;
    logic [1:0] drv_d;
    assign drv_a = pin_drive(nxt_flag, ac_ff, pwm_in_a);
    assign drv_c = pin_drive(nxt_flag, ac_ff, pwm_in_c);
    assign drv_b = pin_drive(nxt_flag, bd_ff, pwm_in_b);
    assign drv_d = pin_drive(nxt_flag, bd_ff, pwm_in_d);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pwm_oe_a, pwm_out_a} <= 2'b10;
            {pwm_oe_b, pwm_out_b} <= 2'b10;
            {pwm_oe_c, pwm_out_c} <= 2'b10;
            {pwm_oe_d, pwm_out_d} <= 2'b10;
        end else begin
            {pwm_oe_a, pwm_out_a} <= drv_a;
            {pwm_oe_b, pwm_out_b} <= drv_b;
            {pwm_oe_c, pwm_out_c} <= drv_c;
            {pwm_oe_d, pwm_out_d} <= drv_d;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign shutdown_event_flag = flag_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_off_never;
        (src_ff == SRC_OFF) && !flag_ff |=> !flag_ff;
    endproperty
    a_off_never: assert property (p_off_never)
        else $error("flag set with sources disabled");

    property p_c1;
        (src_ff == SRC_C1) && cmp1_s |=> flag_ff;
    endproperty
    a_c1: assert property (p_c1)
        else $error("comparator one did not trip");

    property p_c2;
        (src_ff == SRC_C2) && cmp2_s |=> flag_ff;
    endproperty
    a_c2: assert property (p_c2)
        else $error("comparator two did not trip");

    property p_c1c2;
        (src_ff == SRC_C1_C2) && !cmp1_s && !cmp2_s && !flag_ff |=> !flag_ff;
    endproperty
    a_c1c2: assert property (p_c1c2)
        else $error("trip without comparator");

    property p_flt;
        (src_ff == SRC_FLT) && !fault_s |=> flag_ff;
    endproperty
    a_flt: assert property (p_flt)
        else $error("fault low did not trip");

    property p_flt_c1;
        (src_ff == SRC_FLT_C1) && fault_s && !cmp1_s && cmp2_s
            && !flag_ff |=> !flag_ff;
    endproperty
    a_flt_c1: assert property (p_flt_c1)
        else $error("comparator two tripped code 101");

    property p_flt_c2;
        (src_ff == SRC_FLT_C2) && cmp2_s |=> flag_ff;
    endproperty
    a_flt_c2: assert property (p_flt_c2)
        else $error("comparator two did not trip code 110");

    property p_all;
        (src_ff == SRC_ALL) && (cmp1_s || !fault_s) |=> flag_ff;
    endproperty
    a_all: assert property (p_all)
        else $error("code 111 did not trip");

    sequence s_shut_low;
        flag_ff && (ac_ff == PAIR_LOW);
    endsequence
    property p_hold_low;
        s_shut_low ##1 flag_ff |-> pwm_oe_a && !pwm_out_a && !pwm_out_c;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("pair ac not held low");

    property p_tri;
        flag_ff && bd_ff[PAIR_TRI_BIT] && $stable(bd_ff)
            |-> !pwm_oe_b && !pwm_oe_d;
    endproperty
    a_tri: assert property (p_tri)
        else $error("pair bd not floated");

    property p_auto;
        restart_ff && flag_ff && !trip && !wr_restart |=> !flag_ff;
    endproperty
    a_auto: assert property (p_auto)
        else $error("flag not cleared by auto restart");

    sequence s_stuck;
        !restart_ff && flag_ff && !wr_ctrl;
    endsequence
    property p_manual;
        s_stuck |=> flag_ff;
    endproperty
    a_manual: assert property (p_manual)
        else $error("flag cleared without software");
endmodule

// ==== design/pasd_pkg.sv ====
package pasd_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    typedef logic [ADDR_W-1:0] pasd_addr_t;
    typedef logic [DATA_W-1:0] pasd_data_t;
    typedef logic [REG_W-1:0] pasd_reg_t;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam pasd_addr_t ADDR_CTRL = 8'h00;
    localparam pasd_addr_t ADDR_RESTART = 8'h04;
    localparam pasd_addr_t ADDR_STATUS = 8'h08;

    // ------------------------------------------------------------
    // control register fields and reset
    // ------------------------------------------------------------
    localparam int FLAG_BIT = 7;
    localparam int SRC_HI = 6;
    localparam int SRC_LO = 4;
    localparam int AC_HI = 3;
    localparam int AC_LO = 2;
    localparam int BD_HI = 1;
    localparam int BD_LO = 0;
    localparam int RESTART_BIT = 7;
    localparam pasd_reg_t CTRL_RST = 8'h00;
    localparam pasd_reg_t RESTART_RST = 8'h00;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_CMP1_BIT = 1;
    localparam int ST_CMP2_BIT = 2;
    localparam int ST_TRIP_BIT = 3;

    // ------------------------------------------------------------
    // source select codes and pair shutdown states
    // ------------------------------------------------------------
    typedef logic [2:0] pasd_src_t;
    localparam pasd_src_t SRC_OFF = 3'h0;
    localparam pasd_src_t SRC_C1 = 3'h1;
    localparam pasd_src_t SRC_C2 = 3'h2;
    localparam pasd_src_t SRC_C1_C2 = 3'h3;
    localparam pasd_src_t SRC_FLT = 3'h4;
    localparam pasd_src_t SRC_FLT_C1 = 3'h5;
    localparam pasd_src_t SRC_FLT_C2 = 3'h6;
    localparam pasd_src_t SRC_ALL = 3'h7;
    typedef logic [1:0] pasd_pair_t;
    localparam pasd_pair_t PAIR_LOW = 2'h0;
    localparam pasd_pair_t PAIR_HIGH = 2'h1;
    localparam int PAIR_TRI_BIT = 1;

    // ------------------------------------------------------------
    // synchroniser idle levels
    // ------------------------------------------------------------
    localparam logic FAULT_IDLE = 1'b1;
    localparam logic CMP_IDLE = 1'b0;
endpackage

// ==== design/pasd_sync.sv ====
`timescale 1ns/1ps
module pasd_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic level_out
);
    // ------------------------------------------------------------
    // three stage capture, accept change when stages two and three agree
    // ------------------------------------------------------------
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_ff <= RST_VAL;
        end else if (s2_ff == s3_ff) begin
            level_ff <= s3_ff;
        end
    end

    assign level_out = level_ff;
endmodule

// ==== testbench/pasd_fault_src.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// fault pin and comparator model
// ------------------------------------------------------------
module pasd_fault_src (
    input wire logic fault_req,
    input wire logic cmp1_req,
    input wire logic cmp2_req,
    output logic fault_input,
    output logic comparator_one,
    output logic comparator_two
);
    // pin pulled up: idle high, pulled low on a fault
    assign fault_input = ~fault_req;
    // comparator outputs idle low, high on a trip
    assign comparator_one = cmp1_req;
    assign comparator_two = cmp2_req;
endmodule

// ==== testbench/pasd_top_tb_top.sv ====
`timescale 1ns/1ps
module pasd_top_tb_top;
    import pasd_pkg::*;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    pasd_addr_t paddr;
    pasd_data_t pwdata;
    pasd_data_t prdata;
    logic pready;
    logic pslverr;
    logic [3:0] pin;
    logic [3:0] po;
    logic [3:0] oe;
    logic flag;
    logic freq;
    logic c1q;
    logic c2q;
    logic fault_input;
    logic comparator_one;
    logic comparator_two;
    int error_cnt;
    int tests_run;

    // ------------------------------------------------------------
    // clock, partner and design
    // ------------------------------------------------------------
    always #5 pclk = ~pclk;

    pasd_fault_src pasd_fault_src_i (
        .fault_req(freq), .cmp1_req(c1q), .cmp2_req(c2q),
        .fault_input(fault_input), .comparator_one(comparator_one),
        .comparator_two(comparator_two));

    pasd_top pasd_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fault_input(fault_input),
        .comparator_one(comparator_one), .comparator_two(comparator_two),
        .pwm_in_a(pin[3]), .pwm_in_b(pin[2]), .pwm_in_c(pin[1]),
        .pwm_in_d(pin[0]), .pwm_out_a(po[3]), .pwm_out_b(po[2]),
        .pwm_out_c(po[1]), .pwm_out_d(po[0]), .pwm_oe_a(oe[3]),
        .pwm_oe_b(oe[2]), .pwm_oe_c(oe[1]), .pwm_oe_d(oe[0]),
        .shutdown_event_flag(flag));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input pasd_addr_t a,
            input pasd_data_t d, output pasd_data_t rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [7:0] exp_out(logic sd, pasd_pair_t ac,
            pasd_pair_t bd, logic [3:0] p);
        logic [3:0] o;
        logic [3:0] e;
        logic la;
        logic lb;
        la = ac[0] & ~ac[1];
        lb = bd[0] & ~bd[1];
        o = p;
        e = 4'hf;
        if (sd) begin
            o = {la, lb, la, lb};
            e = {~ac[1], ~bd[1], ~ac[1], ~bd[1]};
        end
        return {o, e};
    endfunction

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        pasd_data_t rd;
        logic err;
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
        chk(rd, 32'(CTRL_RST));
        apb(1'b0, ADDR_RESTART, 32'h0, rd, err);
        chk(rd, 32'(RESTART_RST));
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(rd, 32'h1);
        apb(1'b0, 8'h0c, 32'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h37, rd, err);
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
        chk(rd, 32'h37);
        apb(1'b1, ADDR_STATUS, 32'hff, rd, err);
        chk(32'(err), 32'h1);
    endtask

    task automatic t_sources();
        pasd_data_t rd;
        logic err;
        logic trip;
        pasd_pair_t ac;
        pasd_pair_t bd;
        apb(1'b1, ADDR_RESTART, 32'h80, rd, err);
        for (int s = 0; s < 8; s++) begin
            for (int k = 0; k < 8; k++) begin
                ac = k[1:0];
                bd = k[2:1];
                pin <= 4'(s + k);
                apb(1'b1, ADDR_CTRL, {25'h0, 3'(s), ac, bd}, rd, err);
                case (s)
                    0: trip = 1'b0;
                    1: trip = k[1];
                    2: trip = k[2];
                    3: trip = k[1] | k[2];
                    4: trip = k[0];
                    5: trip = k[0] | k[1];
                    6: trip = k[0] | k[2];
                    default: trip = k[0] | k[1] | k[2];
                endcase
                freq <= k[0];
                c1q <= k[1];
                c2q <= k[2];
                wait_n(8);
                chk(32'(flag), 32'(trip));
                chk(32'({po, oe}), 32'(exp_out(trip, ac, bd, pin)));
                freq <= 1'b0;
                c1q <= 1'b0;
                c2q <= 1'b0;
                wait_n(8);
                chk(32'(flag), 32'h0);
                chk(32'({po, oe}), 32'(exp_out(1'b0, ac, bd, pin)));
            end
        end
    endtask

    task automatic t_soft();
        pasd_data_t rd;
        logic err;
        apb(1'b1, ADDR_RESTART, 32'h0, rd, err);
        apb(1'b1, ADDR_CTRL, 32'h41, rd, err);
        pin <= 4'hf;
        freq <= 1'b1;
        wait_n(8);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(rd, 32'h8);
        freq <= 1'b0;
        wait_n(8);
        chk(32'(flag), 32'h1);
        chk(32'({po, oe}), 32'(exp_out(1'b1, 2'h0, 2'h1, 4'hf)));
        apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
        chk(rd, 32'hc1);
        apb(1'b1, ADDR_CTRL, 32'h41, rd, err);
        wait_n(3);
        chk(32'(flag), 32'h0);
        chk(32'({po, oe}), 32'(exp_out(1'b0, 2'h0, 2'h1, 4'hf)));
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pin = 4'h0;
        freq = 1'b0;
        c1q = 1'b0;
        c2q = 1'b0;
        error_cnt = 0;
        tests_run = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_sources();
        t_soft();
        print_verdict();
    end

    initial begin
        repeat (10000) @(posedge pclk);
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
